//--- core/tcf_pkg.sv
`default_nettype none
package tcf_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL = 8'h12;
  localparam logic [7:0] IDX_STS = 8'h13;
  localparam logic [7:0] IDX_CAPH = 8'h14;
  localparam logic [7:0] IDX_CAPL = 8'h15;
  localparam logic [7:0] IDX_CMPH = 8'h16;
  localparam logic [7:0] IDX_CMPL = 8'h17;
  localparam logic [7:0] IDX_CNTH = 8'h18;
  localparam logic [7:0] IDX_CNTL = 8'h19;
  localparam logic [7:0] IDX_ALTH = 8'h1a;
  localparam logic [7:0] IDX_ALTL = 8'h1b;
  localparam logic [7:0] IDX_FIRST = 8'h12;
  localparam logic [7:0] IDX_LAST = 8'h1b;
  // timer_control fields
  localparam int CTL_CAP_IE = 7;
  localparam int CTL_CMP_IE = 6;
  localparam int CTL_OVF_IE = 5;
  localparam int CTL_PIN_EN = 2;
  localparam int CTL_EDGE = 1;
  localparam int CTL_LEVEL = 0;
  localparam logic [7:0] CTL_RW_MASK = 8'he7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // timer_status fields
  localparam int STS_CAP = 7;
  localparam int STS_CMP = 6;
  localparam int STS_OVF = 5;
  // counter and prescaler
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CAP_DELAY = 16'h0001;
  localparam int PRESCALE = 4;
  localparam logic [1:0] PRE_LAST = 2'(PRESCALE - 1);
  localparam logic [1:0] PRE_ZERO = 2'h0;
  localparam logic [1:0] PRE_STEP = 2'h1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- core/tcf_timer.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - capture copies free-running count on selected edge
// - capture register kept across reset
// - captured value is prior count plus one
// - capture resolution is one four-cycle count
// - every unblocked qualifying edge outside stop transfers regardless of flag
// - high-byte read blocks transfers until low read, except the armed stop edge on wake
// - low-byte read alone never blocks transfers
// - control register holds three interrupt enables
// - pin enable routes compare level to pin
// - edge select picks rising or falling, reset-proof
// - level bit loads output register on compare
// - control bits three and four read zero
// - status holds three flags, low bits zero
// - capture flag cleared by status then low capture
// - compare flag cleared by status then compare low
// - overflow flag on rollover, cleared via counter low
// - alternate counter pair never clears overflow
// - timer runs in wait, interrupt wakes core
// - counter frozen in stop, reset forces fffc
// - first stop-mode edge armed, shown on wake
// - reset exit from stop discards armed capture
// - prescaler divides bus clock by four
// - every match outside the high-to-low compare write sets flag and loads level
module tcf_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // core side
  input wire logic core_reset,
  input wire logic stop_mode,
  output logic timer_irq,
  // pins
  input wire logic capture_input_pin,
  input wire logic port_d_bit_six_out,
  input wire logic port_d_bit_six_oe_n,
  output logic compare_output_pin_o,
  output logic compare_output_pin_oe_n
);

  typedef struct packed {
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [7:0] w_d;
    logic w_s;
    logic b_v;
    logic b_err;
    logic r_v;
    logic [7:0] r_d;
    logic r_err;
    logic [7:0] ctl;
    logic capture_flag;
    logic compare_flag;
    logic overflow_flag;
    logic arm_i;
    logic arm_o;
    logic arm_t;
    logic [15:0] cap;
    logic cap_inh;
    logic [15:0] cmp;
    logic cmp_inh;
    logic [15:0] cnt;
    logic [1:0] pre;
    logic [1:0][7:0] lat;
    logic [1:0] lat_v;
    logic olr;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [15:0] cnt_p1;
    logic [15:0] cnt_p2;
    logic stp_armed;
    logic [15:0] stp_cap;
    logic stop_prev;
  } tcf_state_s;

  tcf_state_s s_q;
  tcf_state_s s_d;
  logic tick;
  logic cap_edge;
  logic stop_exit;
  logic cmp_hit;
  logic [15:0] cap_val;

  // returns {valid, index}; unaligned or unmapped addresses are invalid
  function automatic logic [8:0] map_addr(input logic [7:0] a);
    logic [7:0] idx;
    idx = {2'h0, a[7:2]};
    map_addr = {(a[1:0] == 2'h0) && (idx >= tcf_pkg::IDX_FIRST) && (idx <= tcf_pkg::IDX_LAST), idx};
  endfunction

  // status access arms the clear of each flag that is set at that moment
  function automatic tcf_state_s bus_access(input tcf_state_s s, input logic [7:0] idx);
    tcf_state_s r;
    r = s;
    if (idx == tcf_pkg::IDX_STS) begin
      r.arm_i = s.capture_flag;
      r.arm_o = s.compare_flag;
      r.arm_t = s.overflow_flag;
    end
    if (idx == tcf_pkg::IDX_CAPL && s.arm_i) begin
      r.capture_flag = 1'b0;
      r.arm_i = 1'b0;
    end
    if (idx == tcf_pkg::IDX_CMPL && s.arm_o) begin
      r.compare_flag = 1'b0;
      r.arm_o = 1'b0;
    end
    // the alternate pair is deliberately absent here
    if (idx == tcf_pkg::IDX_CNTL && s.arm_t) begin
      r.overflow_flag = 1'b0;
      r.arm_t = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [7:0] rd_byte(input tcf_state_s s, input logic [7:0] idx);
    rd_byte = 8'h00;
    unique case (idx)
      tcf_pkg::IDX_CTL: rd_byte = s.ctl & tcf_pkg::CTL_RW_MASK;
      tcf_pkg::IDX_STS: rd_byte = {s.capture_flag, s.compare_flag, s.overflow_flag, 5'h00};
      tcf_pkg::IDX_CAPH: rd_byte = s.cap[15:8];
      tcf_pkg::IDX_CAPL: rd_byte = s.cap[7:0];
      tcf_pkg::IDX_CMPH: rd_byte = s.cmp[15:8];
      tcf_pkg::IDX_CMPL: rd_byte = s.cmp[7:0];
      tcf_pkg::IDX_CNTH: rd_byte = s.cnt[15:8];
      tcf_pkg::IDX_CNTL: rd_byte = s.lat_v[0] ? s.lat[0] : s.cnt[7:0];
      tcf_pkg::IDX_ALTH: rd_byte = s.cnt[15:8];
      tcf_pkg::IDX_ALTL: rd_byte = s.lat_v[1] ? s.lat[1] : s.cnt[7:0];
      default: rd_byte = 8'h00;
    endcase
  endfunction

  always_comb begin
    logic [8:0] wm;
    logic [8:0] rm;
    wm = map_addr(s_q.aw_a);
    rm = map_addr(araddr);
    s_d = s_q;
    tick = !stop_mode && (s_q.pre == tcf_pkg::PRE_LAST);
    stop_exit = s_q.stop_prev && !stop_mode;
    // the pin is seen two flops late; the count is delayed alongside so the
    // transfer still lands on the count of the edge before the transition
    s_d.sync1 = capture_input_pin;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.cnt_p1 = s_q.cnt;
    s_d.cnt_p2 = s_q.cnt_p1;
    cap_val = s_q.cnt_p2 + tcf_pkg::CAP_DELAY;
    cap_edge = s_q.ctl[tcf_pkg::CTL_EDGE] ? (s_q.sync2 && !s_q.sync3) : (!s_q.sync2 && s_q.sync3);
    cmp_hit = tick && !s_q.cmp_inh && ((s_q.cnt + tcf_pkg::CAP_DELAY) == s_q.cmp);
    s_d.stop_prev = stop_mode;

    // write channel: address and data taken in either order
    if (awvalid && awready) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_v = 1'b1;
      s_d.w_d = wdata[7:0];
      s_d.w_s = wstrb[0];
    end
    if (s_q.b_v && bready) begin
      s_d.b_v = 1'b0;
    end
    if (s_q.aw_v && s_q.w_v && !s_q.b_v) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.b_v = 1'b1;
      s_d.b_err = !wm[8];
      if (wm[8]) begin
        s_d = bus_access(s_d, wm[7:0]);
        if (s_q.w_s) begin
          unique case (wm[7:0])
            tcf_pkg::IDX_CTL: s_d.ctl = s_q.w_d & tcf_pkg::CTL_RW_MASK;
            tcf_pkg::IDX_CMPH: begin
              s_d.cmp[15:8] = s_q.w_d;
              s_d.cmp_inh = 1'b1;
            end
            tcf_pkg::IDX_CMPL: begin
              s_d.cmp[7:0] = s_q.w_d;
              s_d.cmp_inh = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
    end

    // read channel: one read in flight, side effects at the address handshake
    if (s_q.r_v && rready) begin
      s_d.r_v = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.r_v = 1'b1;
      s_d.r_err = !rm[8];
      s_d.r_d = rm[8] ? rd_byte(s_q, rm[7:0]) : 8'h00;
      if (rm[8]) begin
        s_d = bus_access(s_d, rm[7:0]);
        unique case (rm[7:0])
          tcf_pkg::IDX_CAPH: s_d.cap_inh = 1'b1;
          tcf_pkg::IDX_CAPL: s_d.cap_inh = 1'b0;
          tcf_pkg::IDX_CNTH: begin
            if (!s_q.lat_v[0]) begin
              s_d.lat[0] = s_q.cnt[7:0];
            end
            s_d.lat_v[0] = 1'b1;
          end
          tcf_pkg::IDX_CNTL: s_d.lat_v[0] = 1'b0;
          tcf_pkg::IDX_ALTH: begin
            if (!s_q.lat_v[1]) begin
              s_d.lat[1] = s_q.cnt[7:0];
            end
            s_d.lat_v[1] = 1'b1;
          end
          tcf_pkg::IDX_ALTL: s_d.lat_v[1] = 1'b0;
          default: begin
          end
        endcase
      end
    end

    // hardware sets come after bus clears so a same-cycle event wins
    if (!stop_mode) begin
      s_d.pre = s_q.pre + tcf_pkg::PRE_STEP;
    end
    if (tick) begin
      s_d.cnt = s_q.cnt + tcf_pkg::CAP_DELAY;
      if (s_q.cnt == tcf_pkg::CNT_MAX) begin
        s_d.overflow_flag = 1'b1;
      end
    end
    if (cmp_hit) begin
      s_d.compare_flag = 1'b1;
      s_d.olr = s_q.ctl[tcf_pkg::CTL_LEVEL];
    end
    if (stop_exit && s_q.stp_armed) begin
      s_d.cap = s_q.stp_cap;
      s_d.capture_flag = 1'b1;
      s_d.stp_armed = 1'b0;
    end
    if (cap_edge) begin
      if (stop_mode) begin
        // only the first edge in stop is kept, and it raises nothing yet
        if (!s_q.stp_armed) begin
          s_d.stp_armed = 1'b1;
          s_d.stp_cap = cap_val;
        end
      end else begin
        // the block is taken from the register, so a low-byte read that
        // meets an edge frees only later edges; a lone low read never blocks
        if (!s_q.cap_inh) begin
          s_d.cap = cap_val;
        end
        s_d.capture_flag = 1'b1;
      end
    end

    // core reset: capture data and edge select survive it
    if (core_reset) begin
      s_d.cnt = tcf_pkg::CNT_RESET;
      s_d.pre = tcf_pkg::PRE_ZERO;
      s_d.ctl = (tcf_pkg::CTL_RESET & ~(8'h01 << tcf_pkg::CTL_EDGE)) | (s_q.ctl & (8'h01 << tcf_pkg::CTL_EDGE));
      s_d.capture_flag = 1'b0;
      s_d.compare_flag = 1'b0;
      s_d.overflow_flag = 1'b0;
      s_d.arm_i = 1'b0;
      s_d.arm_o = 1'b0;
      s_d.arm_t = 1'b0;
      s_d.cap = s_q.cap;
      s_d.cap_inh = 1'b0;
      s_d.cmp_inh = 1'b0;
      s_d.lat_v = 2'h0;
      s_d.stp_armed = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.cnt <= tcf_pkg::CNT_RESET;
      s_q.ctl <= tcf_pkg::CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = !s_q.aw_v && !s_q.b_v;
  assign wready = !s_q.w_v && !s_q.b_v;
  assign bvalid = s_q.b_v;
  assign bresp = s_q.b_err ? tcf_pkg::RESP_SLVERR : tcf_pkg::RESP_OKAY;
  assign arready = !s_q.r_v;
  assign rvalid = s_q.r_v;
  assign rdata = {24'h000000, s_q.r_d};
  assign rresp = s_q.r_err ? tcf_pkg::RESP_SLVERR : tcf_pkg::RESP_OKAY;
  // stays live in wait because the timer clock never stops there
  assign timer_irq = (s_q.capture_flag && s_q.ctl[tcf_pkg::CTL_CAP_IE]) ||
                     (s_q.compare_flag && s_q.ctl[tcf_pkg::CTL_CMP_IE]) ||
                     (s_q.overflow_flag && s_q.ctl[tcf_pkg::CTL_OVF_IE]);
  assign compare_output_pin_o = s_q.ctl[tcf_pkg::CTL_PIN_EN] ? s_q.olr : port_d_bit_six_out;
  assign compare_output_pin_oe_n = s_q.ctl[tcf_pkg::CTL_PIN_EN] ? 1'b0 : port_d_bit_six_oe_n;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_run_edge;
    cap_edge && !stop_mode && !core_reset;
  endsequence
  sequence seq_match;
    cmp_hit && !core_reset;
  endsequence

  AST_CAP_XFER: assert property (seq_run_edge ##0 !s_q.cap_inh |=> s_q.cap == $past(s_q.cnt_p2) + 16'h0001)
    else $error("capture did not load count plus one");
  AST_CAP_BLOCK: assert property (s_q.cap_inh && !stop_exit |=> $stable(s_q.cap))
    else $error("capture changed while blocked");
  AST_CAPFLAG_SET: assert property (seq_run_edge |=> s_q.capture_flag)
    else $error("capture flag not set on edge");
  AST_OVFLAG_SET: assert property (tick && s_q.cnt == 16'hffff && !core_reset |=> s_q.overflow_flag && s_q.cnt == 16'h0000)
    else $error("rollover did not set overflow");
  AST_PRESCALE: assert property (tick |=> !tick [*3])
    else $error("counter advanced faster than every four cycles");
  AST_STOP_FREEZE: assert property (stop_mode && !core_reset |=> $stable(s_q.cnt))
    else $error("counter moved in stop");
  AST_RESET_CNT: assert property (core_reset |=> s_q.cnt == 16'hfffc && !s_q.stp_armed)
    else $error("reset did not force count");
  AST_MATCH: assert property (seq_match |=> s_q.compare_flag && s_q.olr == $past(s_q.ctl[0]))
    else $error("compare match missed flag or level");
  AST_STOP_QUIET: assert property (cap_edge && stop_mode |=> !$rose(s_q.capture_flag))
    else $error("edge in stop raised a flag");
  AST_IRQ_OVF: assert property (s_q.overflow_flag && s_q.ctl[5] |-> timer_irq)
    else $error("enabled overflow gave no interrupt");

endmodule

`default_nettype wire

//--- testbench/tcf_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcf_pin_model (
  // clock and stimulus from the bench
  input wire logic aclk,
  input wire logic cap_lvl,
  // pins toward the timer
  output logic capture_input_pin,
  output logic port_d_bit_six_out,
  output logic port_d_bit_six_oe_n
);
  logic pin_q = 1'b0;
  logic [1:0] pat_q = 2'h0;
  // the pin moves one edge after the request, unrelated to the timer's phase
  always_ff @(posedge aclk) begin
    pin_q <= cap_lvl;
    pat_q <= pat_q + 2'h1;
  end
  assign capture_input_pin = pin_q;
  // port d level changes every cycle and enable every second cycle so a stuck mux cannot hide
  assign port_d_bit_six_out = pat_q[0];
  assign port_d_bit_six_oe_n = pat_q[1];
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [7:0] CTL = tcf_pkg::IDX_CTL;
  localparam logic [7:0] STS = tcf_pkg::IDX_STS;
  localparam logic [7:0] CAPH = tcf_pkg::IDX_CAPH;
  localparam logic [7:0] CAPL = tcf_pkg::IDX_CAPL;
  localparam logic [7:0] CMPL = tcf_pkg::IDX_CMPL;
  localparam logic [7:0] ALTH = tcf_pkg::IDX_ALTH;
  localparam logic [7:0] ALTL = tcf_pkg::IDX_ALTL;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  // response channels always accept, which keeps ready high until valid
  logic bready = 1'b1, rready = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic core_reset = 1'b0, stop_mode = 1'b0, cap_lvl = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, timer_irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic capture_input_pin, port_d_bit_six_out, port_d_bit_six_oe_n;
  logic compare_output_pin_o, compare_output_pin_oe_n;
  logic [15:0] c1, c2;
  int miscompares = 0;
  int checked = 0;

  always #5 aclk = ~aclk;

  tcf_pin_model u_pins (.aclk, .cap_lvl, .capture_input_pin, .port_d_bit_six_out, .port_d_bit_six_oe_n);

  tcf_timer u_dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .core_reset, .stop_mode, .timer_irq, .capture_input_pin,
    .port_d_bit_six_out, .port_d_bit_six_oe_n, .compare_output_pin_o,
    .compare_output_pin_oe_n
  );

  task automatic test_done;
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic hang;
    miscompares++;
    test_done();
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // readies are sampled mid-cycle so the taking edge is known before it comes
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic a, w, b;
    int n;
    awaddr <= {i[5:0], 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 1'b0;
    for (n = 0; !b; n++) begin
      if (n > 50) hang();
      @(negedge aclk);
      a = awready;
      w = wready;
      b = bvalid;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    chk(32'(bresp), 32'h0);
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] q, output logic [1:0] e);
    logic a, b;
    int n;
    araddr <= {i[5:0], 2'h0};
    arvalid <= 1'b1;
    b = 1'b0;
    for (n = 0; !b; n++) begin
      if (n > 50) hang();
      @(negedge aclk);
      a = arready;
      b = rvalid;
      q = rdata;
      e = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
  endtask

  task automatic rc(input logic [7:0] i, input logic [7:0] x);
    rd(i, d, r);
    chk(d, {24'h0, x});
    chk(32'(r), 32'h0);
  endtask

  task automatic rp(input logic [7:0] h, output logic [15:0] v);
    rd(h, d, r);
    v[15:8] = d[7:0];
    rd(h + 8'h1, d, r);
    v[7:0] = d[7:0];
  endtask

  // pin lag plus two-flop synchroniser settle well inside six edges
  task automatic pin(input logic v);
    cap_lvl <= v;
    repeat (6) @(posedge aclk);
  endtask

  // flags after reset, interrupt enables, clearing sequences, error response
  task automatic scn_flags;
    rc(STS, 8'h00);
    repeat (20) @(posedge aclk);
    rc(STS, 8'h60);
    wr(CTL, 8'hff);
    rc(CTL, 8'he7);
    chk(32'(timer_irq), 32'h1);
    wr(CTL, 8'h20);
    rc(STS, 8'h60);
    rd(ALTL, d, r);
    rc(STS, 8'h60);
    rd(tcf_pkg::IDX_CNTL, d, r);
    rc(STS, 8'h40);
    chk(32'(timer_irq), 32'h0);
    rd(CMPL, d, r);
    rc(STS, 8'h00);
    wr(STS, 8'hff);
    rc(STS, 8'h00);
    rd(8'h11, d, r);
    chk({r, d[29:0]}, {tcf_pkg::RESP_SLVERR, 30'h0});
  endtask

  // edge select, blocking by the high byte and release by the low byte
  task automatic scn_capture;
    wr(CTL, 8'h02);
    pin(1'b1);
    rc(STS, 8'h80);
    rp(CAPH, c1);
    rc(STS, 8'h00);
    pin(1'b0);
    rc(STS, 8'h00);
    rd(CAPH, d, r);
    pin(1'b1);
    rc(STS, 8'h80);
    rc(CAPL, c1[7:0]);
    pin(1'b0);
    pin(1'b1);
    rd(CAPL, d, r);
    chk(32'(d[7:0] != c1[7:0]), 32'h1);
    rd(STS, d, r);
    rd(CAPL, d, r);
  endtask

  // frozen count in stop, armed first edge shown on wake
  task automatic scn_stop;
    stop_mode <= 1'b1;
    pin(1'b0);
    rp(ALTH, c1);
    repeat (20) @(posedge aclk);
    rp(ALTH, c2);
    chk({16'h0, c2}, {16'h0, c1});
    pin(1'b1);
    rc(STS, 8'h00);
    stop_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    rc(STS, 8'h80);
    rp(CAPH, c2);
    chk({16'h0, c2}, {16'h0, c1 + 16'h1});
  endtask

  // core reset out of stop drops the armed edge but keeps capture data
  task automatic scn_core_reset;
    stop_mode <= 1'b1;
    pin(1'b0);
    pin(1'b1);
    core_reset <= 1'b1;
    @(posedge aclk);
    core_reset <= 1'b0;
    stop_mode <= 1'b0;
    rc(tcf_pkg::IDX_CNTH, 8'hff);
    rc(STS, 8'h00);
    rc(CTL, 8'h02);
    rp(CAPH, c1);
    chk({16'h0, c1}, {16'h0, c2});
  endtask

  // compare match drives the level onto the pin, then the pin returns to port d
  task automatic scn_compare;
    int n;
    wr(tcf_pkg::IDX_CMPH, 8'h00);
    wr(CMPL, 8'h40);
    wr(CTL, 8'h07);
    chk(32'(compare_output_pin_o), 32'h0);
    chk(32'(compare_output_pin_oe_n), 32'h0);
    for (n = 0; compare_output_pin_o !== 1'b1; n++) begin
      if (n > 600) hang();
      @(posedge aclk);
    end
    rc(STS, 8'h60);
    rd(CMPL, d, r);
    rc(STS, 8'h20);
    wr(CTL, 8'h02);
    repeat (4) begin
      @(negedge aclk);
      chk(32'(compare_output_pin_o), 32'(port_d_bit_six_out));
      chk(32'(compare_output_pin_oe_n), 32'(port_d_bit_six_oe_n));
    end
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    scn_flags();
    scn_capture();
    scn_stop();
    scn_core_reset();
    scn_compare();
    @(posedge aclk);
    test_done();
  end
endmodule
`default_nettype wire
